// ### rtl/ucs_pkg.sv
// constants and types shared by the serial control and status block
package ucs_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS_A = 8'hC0;
  localparam logic [7:0] IDX_CTRL_B = 8'hC1;
  localparam logic [7:0] IDX_CTRL_C = 8'hC2;
  localparam logic [7:0] IDX_DATA = 8'hC6;
  localparam logic [7:0] IDX_IRQ_GLOBAL = 8'hC8;
  localparam int ADDR_W = 12;

  // status register a bit positions
  localparam int BIT_RXC = 7;
  localparam int BIT_TXC = 6;
  localparam int BIT_UDRE = 5;
  localparam int BIT_FE = 4;
  localparam int BIT_DOR = 3;
  localparam int BIT_UPE = 2;
  localparam int BIT_U2X = 1;
  localparam int BIT_MPCM = 0;

  // control register b bit positions
  localparam int BIT_RXCIE = 7;
  localparam int BIT_TXCIE = 6;
  localparam int BIT_UDRIE = 5;
  localparam int BIT_RXEN = 4;
  localparam int BIT_TXEN = 3;
  localparam int BIT_CSZ2 = 2;
  localparam int BIT_RX9 = 1;
  localparam int BIT_TX9 = 0;

  // reset values
  localparam logic [7:0] RST_STATUS_A = 8'h20;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [7:0] RST_CTRL_C = 8'h06;

  // mode, parity and size encodings
  localparam logic [1:0] MODE_ASYNC = 2'h0;
  localparam logic [1:0] MODE_SYNC = 2'h1;
  localparam logic [1:0] MODE_SPI = 2'h3;
  localparam logic [1:0] PAR_ODD = 2'h3;
  localparam logic [2:0] SIZE_9 = 3'h7;

  // rate ticks per bit
  localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
  localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
  localparam logic [4:0] SAMPLES_SYNC = 5'h02;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_START = 5'h02,
    TX_DATA = 5'h04,
    TX_PARITY = 5'h08,
    TX_STOP = 5'h10
  } ucs_tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_PARITY = 5'h08,
    RX_STOP = 5'h10
  } ucs_rx_state_t;

endpackage : ucs_pkg

// ### rtl/ucs_rate_div.sv
// rate divider giving a one-cycle tick every RATE_DIV clocks
module ucs_rate_div #(
  parameter int RATE_DIV = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick
);

  logic [15:0] count;

  // free running; the divisor is the fixed RATE_DIV parameter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count <= 16'h0000;
      tick <= 1'b0;
    end
    else if (count == 16'(RATE_DIV - 1))
    begin
      count <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      count <= count + 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule : ucs_rate_div

// ### rtl/ucs_top.sv
// serial receiver/transmitter control, status and framing with bus slave
// Summary of operation
// - receive-complete bit 7 is high while the receive queue holds data
// - disabling the receiver flushes the queue, clearing receive-complete
// - transmit-complete bit 6 sets after frame out with buffer empty
// - buffer-empty bit 5 shows transmit buffer free; one after reset
// - frame error bit 4 when head character's first stop bit was zero
// - overrun bit 3 when start arrives with queue full and shifter full
// - parity error bit 2 for head character failing an enabled check
// - speed-double changes async divider 16 to 8; zero when synchronous
// - multi-processor filter drops frames without address mark; tx unaffected
// - each interrupt needs its enable, global flag and status flag
// - receiver enable takes rx pin; disable flushes and drops errors
// - transmitter takes tx pin; disable waits until all data sent
// - ninth received bit readable; software reads it before low bits
// - mode 00 async, 01 sync, 11 master spi, 10 reserved
// - spi order, phase and polarity accepted in the mode-setting write
// - parity 00 off, 10 even, 11 odd; tx appends, rx checks
// - stop select gives one or two transmitted stops; rx ignores it
// - size 000-011 gives 5-8 bits, 111 gives 9; others reserved
// - in spi mode data order one sends lsb first, zero msb
// - in spi mode error, speed, filter, ninth, size2, parity, stop unused
// - receive queue holds two entries, advancing on data register reads
// - transmit data writes are dropped while buffer-empty is clear
module ucs_top #(
  parameter int RATE_DIV = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ucs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ucs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_rx_pin,
  output logic rx_pin_owned,
  output logic serial_tx_pin,
  output logic serial_tx_oe,
  input wire logic tx_complete_irq_ack,
  output logic rx_complete_irq,
  output logic tx_complete_irq,
  output logic tx_empty_irq
);

  // software controls
  logic speed_double, multiproc_filter, irq_global;
  logic rx_complete_irq_en, tx_complete_irq_en, tx_empty_irq_en;
  logic receiver_enable, transmitter_enable, char_size_bit2, tx_ninth_bit;
  logic [7:0] ctrl_c;
  logic tx_complete_flag;
  // bus state
  logic aw_held, w_held;
  logic [ucs_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic wr_fire, rd_fire, pop;
  // transmit path
  logic [8:0] tx_buf;
  logic tx_buf_full, tx_done;
  ucs_pkg::ucs_tx_state_t tx_state;
  logic [8:0] tx_shift;
  logic [3:0] tx_idx;
  logic [4:0] tx_samp;
  logic tx_stop2, tx_level;
  // receive path
  logic rx_meta, rx_sync, rx_prev;
  ucs_pkg::ucs_rx_state_t rx_state;
  logic [8:0] rx_shift;
  logic [3:0] rx_idx;
  logic [4:0] rx_samp;
  logic rx_par_bit, rx_done, rx_start;
  logic [11:0] rx_word;
  logic [11:0] pend;
  logic pend_valid;
  logic [11:0] q_mem [2];
  logic q_head;
  logic [1:0] q_count;
  logic [11:0] head;
  // shared framing values
  logic tick, spi, mode_ok, par_en, par_odd;
  logic [1:0] operating_mode_select, parity_mode;
  logic [2:0] char_size_code;
  logic [3:0] nbits;
  logic [4:0] spb, half;
  logic bit_end_tx, bit_end_rx;

  ucs_rate_div #(
    .RATE_DIV(RATE_DIV)
  ) u_rate (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  // decoded configuration
  assign operating_mode_select = ctrl_c[7:6];
  assign parity_mode = ctrl_c[5:4];
  assign char_size_code = {char_size_bit2, ctrl_c[2:1]};
  assign spi = (operating_mode_select == ucs_pkg::MODE_SPI);
  // mode 10 is reserved: both engines stay idle
  assign mode_ok = (operating_mode_select != 2'h2);
  assign par_en = parity_mode[1] && !spi;
  assign par_odd = (parity_mode == ucs_pkg::PAR_ODD);
  assign head = q_mem[q_head];

  // character length; reserved codes fall back to eight bits
  always_comb
  begin
    case (char_size_code)
      3'h0: nbits = 4'h5;
      3'h1: nbits = 4'h6;
      3'h2: nbits = 4'h7;
      ucs_pkg::SIZE_9: nbits = 4'h9;
      default: nbits = 4'h8;
    endcase
    if (spi)
      nbits = 4'h8;
  end

  // ticks per bit; doubling only matters in async mode
  always_comb
  begin
    if (operating_mode_select != ucs_pkg::MODE_ASYNC)
      spb = ucs_pkg::SAMPLES_SYNC;
    else if (speed_double)
      spb = ucs_pkg::SAMPLES_DOUBLE;
    else
      spb = ucs_pkg::SAMPLES_NORMAL;
    half = spb >> 1;
  end

  assign bit_end_tx = tick && (tx_samp == spb - 5'h01);
  assign bit_end_rx = tick && (rx_samp == spb - 5'h01);

  // bus handshakes: one write and one read in flight each
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign pop = rd_fire && (s_axi_araddr[ucs_pkg::ADDR_W-1:2]
    == {2'b00, ucs_pkg::IDX_DATA}) && (q_count != 2'h0);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ucs_pkg::RESP_OKAY;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_lane0 <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        case (aw_addr[ucs_pkg::ADDR_W-1:2])
          {2'b00, ucs_pkg::IDX_STATUS_A}, {2'b00, ucs_pkg::IDX_CTRL_B},
          {2'b00, ucs_pkg::IDX_CTRL_C}, {2'b00, ucs_pkg::IDX_DATA},
          {2'b00, ucs_pkg::IDX_IRQ_GLOBAL}:
            s_axi_bresp <= ucs_pkg::RESP_OKAY;
          default: s_axi_bresp <= ucs_pkg::RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // control register writes; only byte lane zero carries data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      speed_double <= ucs_pkg::RST_STATUS_A[ucs_pkg::BIT_U2X];
      multiproc_filter <= ucs_pkg::RST_STATUS_A[ucs_pkg::BIT_MPCM];
      {rx_complete_irq_en, tx_complete_irq_en, tx_empty_irq_en} <= 3'h0;
      {receiver_enable, transmitter_enable} <= 2'h0;
      char_size_bit2 <= ucs_pkg::RST_CTRL_B[ucs_pkg::BIT_CSZ2];
      tx_ninth_bit <= ucs_pkg::RST_CTRL_B[ucs_pkg::BIT_TX9];
      ctrl_c <= ucs_pkg::RST_CTRL_C;
      irq_global <= 1'b0;
    end
    else if (wr_fire && w_lane0)
    begin
      case (aw_addr[ucs_pkg::ADDR_W-1:2])
        {2'b00, ucs_pkg::IDX_STATUS_A}:
        begin
          // error positions are read-only, so written zeros are harmless
          speed_double <= w_data[ucs_pkg::BIT_U2X];
          multiproc_filter <= w_data[ucs_pkg::BIT_MPCM];
        end
        {2'b00, ucs_pkg::IDX_CTRL_B}:
        begin
          rx_complete_irq_en <= w_data[ucs_pkg::BIT_RXCIE];
          tx_complete_irq_en <= w_data[ucs_pkg::BIT_TXCIE];
          tx_empty_irq_en <= w_data[ucs_pkg::BIT_UDRIE];
          receiver_enable <= w_data[ucs_pkg::BIT_RXEN];
          transmitter_enable <= w_data[ucs_pkg::BIT_TXEN];
          char_size_bit2 <= w_data[ucs_pkg::BIT_CSZ2];
          tx_ninth_bit <= w_data[ucs_pkg::BIT_TX9];
        end
        // order, phase and polarity land with the mode bits at once
        {2'b00, ucs_pkg::IDX_CTRL_C}: ctrl_c <= w_data[7:0];
        {2'b00, ucs_pkg::IDX_IRQ_GLOBAL}: irq_global <= w_data[0];
        default: ;
      endcase
    end
  end

  // register read mux; error bits describe the queue head
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_rresp = ucs_pkg::RESP_OKAY;
    case (s_axi_araddr[ucs_pkg::ADDR_W-1:2])
      {2'b00, ucs_pkg::IDX_STATUS_A}:
        next_rdata[7:0] = {q_count != 2'h0, tx_complete_flag,
          !tx_buf_full, {head[9], head[11], head[10]} & {3{!spi}},
          speed_double, multiproc_filter};
      {2'b00, ucs_pkg::IDX_CTRL_B}:
        next_rdata[7:0] = {rx_complete_irq_en, tx_complete_irq_en,
          tx_empty_irq_en, receiver_enable, transmitter_enable,
          char_size_bit2, head[8] && !spi, tx_ninth_bit};
      {2'b00, ucs_pkg::IDX_CTRL_C}: next_rdata[7:0] = ctrl_c;
      {2'b00, ucs_pkg::IDX_DATA}: next_rdata[7:0] = head[7:0];
      {2'b00, ucs_pkg::IDX_IRQ_GLOBAL}: next_rdata[0] = irq_global;
      default: next_rresp = ucs_pkg::RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ucs_pkg::RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // transmit buffer; a write while full is simply lost
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_buf_full <= !ucs_pkg::RST_STATUS_A[ucs_pkg::BIT_UDRE];
      tx_buf <= 9'h000;
    end
    else if (wr_fire && w_lane0 && !tx_buf_full && (aw_addr
      [ucs_pkg::ADDR_W-1:2] == {2'b00, ucs_pkg::IDX_DATA}))
    begin
      tx_buf <= {tx_ninth_bit, w_data[7:0]};
      tx_buf_full <= 1'b1;
    end
    else if (tx_state == ucs_pkg::TX_IDLE && serial_tx_oe && mode_ok)
      tx_buf_full <= 1'b0;
  end

  // pin stays ours after disable until shifter and buffer drain
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      serial_tx_oe <= 1'b0;
    else
      serial_tx_oe <= transmitter_enable || (serial_tx_oe &&
        (tx_buf_full || tx_state != ucs_pkg::TX_IDLE));
  end

  // transmit framing engine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_state <= ucs_pkg::TX_IDLE;
      tx_shift <= 9'h000;
      tx_idx <= 4'h0;
      tx_samp <= 5'h00;
      tx_stop2 <= 1'b0;
      tx_done <= 1'b0;
    end
    else
    begin
      tx_done <= 1'b0;
      if (tx_state != ucs_pkg::TX_IDLE && tick)
        tx_samp <= bit_end_tx ? 5'h00 : tx_samp + 5'h01;
      case (tx_state)
        ucs_pkg::TX_IDLE:
          if (tx_buf_full && serial_tx_oe && mode_ok)
          begin
            tx_shift <= tx_buf & (9'h1FF >> (4'h9 - nbits));
            tx_idx <= 4'h0;
            tx_samp <= 5'h00;
            tx_stop2 <= 1'b0;
            tx_state <= spi ? ucs_pkg::TX_DATA : ucs_pkg::TX_START;
          end
        ucs_pkg::TX_START:
          if (bit_end_tx)
            tx_state <= ucs_pkg::TX_DATA;
        ucs_pkg::TX_DATA:
          if (bit_end_tx)
          begin
            tx_idx <= tx_idx + 4'h1;
            if (tx_idx == nbits - 4'h1)
            begin
              if (spi)
              begin
                tx_state <= ucs_pkg::TX_IDLE;
                tx_done <= 1'b1;
              end
              else
                tx_state <= par_en ? ucs_pkg::TX_PARITY
                  : ucs_pkg::TX_STOP;
            end
          end
        ucs_pkg::TX_PARITY:
          if (bit_end_tx)
            tx_state <= ucs_pkg::TX_STOP;
        ucs_pkg::TX_STOP:
          if (bit_end_tx)
          begin
            if (ctrl_c[3] && !tx_stop2)
              tx_stop2 <= 1'b1;
            else
            begin
              tx_state <= ucs_pkg::TX_IDLE;
              tx_done <= 1'b1;
            end
          end
        default: tx_state <= ucs_pkg::TX_IDLE;
      endcase
    end
  end

  // line level for the current bit; spi order picks the end
  always_comb
  begin
    case (tx_state)
      ucs_pkg::TX_START: tx_level = 1'b0;
      ucs_pkg::TX_DATA:
        if (spi && !ctrl_c[2])
          tx_level = tx_shift[3'h7 - tx_idx[2:0]];
        else
          tx_level = tx_shift[tx_idx];
      ucs_pkg::TX_PARITY: tx_level = (^tx_shift) ^ par_odd;
      default: tx_level = 1'b1;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      serial_tx_pin <= 1'b1;
    else
      serial_tx_pin <= tx_level;
  end

  // transmit-complete: set beats clear, service or write-one clears
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_complete_flag <= ucs_pkg::RST_STATUS_A[ucs_pkg::BIT_TXC];
    else if (tx_done && !tx_buf_full)
      tx_complete_flag <= 1'b1;
    else if (tx_complete_irq_ack || (wr_fire && w_lane0 &&
      w_data[ucs_pkg::BIT_TXC] && (aw_addr[ucs_pkg::ADDR_W-1:2]
      == {2'b00, ucs_pkg::IDX_STATUS_A})))
      tx_complete_flag <= 1'b0;
  end

  // pin synchroniser; rx_meta feeds only rx_sync
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
      rx_pin_owned <= 1'b0;
    end
    else
    begin
      rx_meta <= serial_rx_pin;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
      rx_pin_owned <= receiver_enable;
    end
  end

  // receive framing engine; samples mid-bit, ignores stop select
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !receiver_enable)
    begin
      rx_state <= ucs_pkg::RX_IDLE;
      rx_shift <= 9'h000;
      rx_idx <= 4'h0;
      rx_samp <= 5'h00;
      rx_par_bit <= 1'b0;
      rx_done <= 1'b0;
      rx_start <= 1'b0;
      rx_word <= 12'h000;
    end
    else
    begin
      rx_done <= 1'b0;
      rx_start <= 1'b0;
      if (rx_state != ucs_pkg::RX_IDLE && tick)
        rx_samp <= bit_end_rx ? 5'h00 : rx_samp + 5'h01;
      case (rx_state)
        ucs_pkg::RX_IDLE:
          // a start needs the line high first, so a long low after a
          // zero stop bit is not taken for another frame
          if (mode_ok && (spi || (rx_prev && !rx_sync)))
          begin
            rx_shift <= 9'h000;
            rx_idx <= 4'h0;
            rx_samp <= spi ? half : 5'h00;
            rx_start <= !spi;
            rx_state <= spi ? ucs_pkg::RX_DATA : ucs_pkg::RX_START;
          end
        ucs_pkg::RX_START:
          if (tick && rx_samp == half - 5'h01)
          begin
            rx_samp <= 5'h00;
            rx_state <= rx_sync ? ucs_pkg::RX_IDLE : ucs_pkg::RX_DATA;
          end
        ucs_pkg::RX_DATA:
          if (bit_end_rx)
          begin
            if (spi && !ctrl_c[2])
              rx_shift[3'h7 - rx_idx[2:0]] <= rx_sync;
            else
              rx_shift[rx_idx] <= rx_sync;
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx == nbits - 4'h1)
            begin
              if (spi)
              begin
                rx_word <= {3'h0, rx_shift[8], rx_shift[7:1], rx_sync};
                rx_word[7:0] <= ctrl_c[2] ? {rx_sync, rx_shift[6:0]}
                  : {rx_shift[7:1], rx_sync};
                rx_done <= 1'b1;
                rx_state <= ucs_pkg::RX_IDLE;
              end
              else
                rx_state <= par_en ? ucs_pkg::RX_PARITY
                  : ucs_pkg::RX_STOP;
            end
          end
        ucs_pkg::RX_PARITY:
          if (bit_end_rx)
          begin
            rx_par_bit <= rx_sync;
            rx_state <= ucs_pkg::RX_STOP;
          end
        ucs_pkg::RX_STOP:
          if (bit_end_rx)
          begin
            rx_state <= ucs_pkg::RX_IDLE;
            // address mark: ninth bit, else the first stop bit
            rx_done <= !(multiproc_filter && ((char_size_code ==
              ucs_pkg::SIZE_9) ? !rx_shift[8] : !rx_sync));
            rx_word <= {1'b0,
              par_en && (rx_par_bit != ((^rx_shift) ^ par_odd)),
              !rx_sync, rx_shift};
          end
        default: rx_state <= ucs_pkg::RX_IDLE;
      endcase
    end
  end

  // shifter holding slot and two-entry queue, flushed on rx disable
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !receiver_enable)
    begin
      pend <= 12'h000;
      pend_valid <= 1'b0;
      q_head <= 1'b0;
      q_count <= 2'h0;
      q_mem[0] <= 12'h000;
      q_mem[1] <= 12'h000;
    end
    else
    begin
      if (rx_start && q_count == 2'h2 && pend_valid && !pop)
        pend[11] <= 1'b1;
      if (rx_done && !(pend_valid && !(q_count != 2'h2 || pop)))
      begin
        pend <= rx_word;
        pend_valid <= 1'b1;
      end
      else if (pend_valid && (q_count != 2'h2 || pop))
        pend_valid <= 1'b0;
      if (pend_valid && (q_count != 2'h2 || pop))
        q_mem[q_head ^ q_count[0]] <= pend;
      if (pop)
        q_head <= !q_head;
      q_count <= q_count + {1'b0, pend_valid && (q_count != 2'h2 || pop)}
        - {1'b0, pop};
    end
  end

  // interrupt requests gated by enable, global flag and status
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_complete_irq <= 1'b0;
      tx_complete_irq <= 1'b0;
      tx_empty_irq <= 1'b0;
    end
    else
    begin
      rx_complete_irq <= rx_complete_irq_en && irq_global
        && (q_count != 2'h0);
      tx_complete_irq <= tx_complete_irq_en && irq_global
        && tx_complete_flag;
      tx_empty_irq <= tx_empty_irq_en && irq_global && !tx_buf_full;
    end
  end

endmodule : ucs_top

// ### dv/ucs_checker.sv
// checker of bus handshakes and transmit line framing
module ucs_checker #(
  parameter int RATE_DIV = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_tx_pin,
  input wire logic serial_tx_oe
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // both write channels taken on one edge
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // a start bit lasts a whole bit, far longer than four clocks
  sequence s_low;
    !serial_tx_pin [*4];
  endsequence
  AST_B_AFTER: assert property (s_wr |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
  AST_W_BLOCK: assert property (s_axi_bvalid |->
    !(s_axi_awready || s_axi_wready))
    else $error("write taken while answering");
  AST_R_AFTER: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer missing");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
  AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  AST_TX_IDLE: assert property (!serial_tx_oe |-> serial_tx_pin)
    else $error("released line not idle");
  AST_TX_START: assert property ($fell(serial_tx_pin) |->
    serial_tx_oe ##1 s_low)
    else $error("start bit too short or unowned");
endmodule : ucs_checker

bind ucs_top ucs_checker #(.RATE_DIV(RATE_DIV)) i_chk (.*);

// ### dv/ucs_peer.sv
// remote serial peer sending and taking asynchronous frames
module ucs_peer #(
  parameter int BIT = 16
) (
  input wire logic aclk,
  output logic serial_rx_pin,
  input wire logic serial_tx_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial serial_rx_pin = 1'h1;
  // one frame, lsb first; a zero stop level makes a framing fault
  task automatic send(input logic [7:0] dat, input logic stp);
    logic [9:0] f;
    f = {stp, dat, 1'h0};
    for (int i = 0; i < 10; i++)
    begin
      serial_rx_pin <= f[i];
      repeat (BIT) @(posedge aclk);
    end
    serial_rx_pin <= 1'h1;
    repeat (BIT) @(posedge aclk);
  endtask : send
  // samples mid-bit; ok reports a proper stop level
  task automatic take(output logic [7:0] dat, output logic ok);
    int n;
    for (n = 0; n < 4000 && serial_tx_pin !== 1'h0; n++)
      @(posedge aclk);
    // no start bit seen: report a bad frame and give up
    ok = 1'h0;
    if (n == 4000)
      return;
    repeat (BIT / 2) @(posedge aclk);
    for (n = 0; n < 8; n++)
    begin
      repeat (BIT) @(posedge aclk);
      dat[n] = serial_tx_pin;
    end
    repeat (BIT) @(posedge aclk);
    ok = (serial_tx_pin === 1'h1);
  endtask : take
endmodule : ucs_peer

// ### dv/uart_control_status_tb_top.sv
// self-checking bench for the serial control and status block
module uart_control_status_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0;
  logic [11:0] s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  // response readies stay high; answers are taken on the edge seen
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h1;
  logic tx_complete_irq_ack = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, serial_rx_pin, rx_pin_owned, serial_tx_pin;
  logic serial_tx_oe, rx_complete_irq, tx_complete_irq, tx_empty_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata;
  logic [7:0] d;
  logic ok;
  int error_cnt = 0;
  int cmp_count = 0;
  // one bit is 16 clocks with the divider at one
  ucs_top #(.RATE_DIV(1)) i_dut (.*);
  ucs_peer i_peer (.aclk, .serial_rx_pin, .serial_tx_pin);
  always #20 aclk = ~aclk;
  task automatic report_and_stop;
    $display("mismatches %0d in %0d compares", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // each channel released on its own handshake; a stuck bus ends the run
  task automatic wr(input logic [7:0] i, dat);
    int n;
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, dat};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (n = 0; n < 60; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) break;
    end
    r = s_axi_bresp;
    if (n == 60)
    begin
      error_cnt++;
      report_and_stop();
    end
  endtask : wr
  task automatic rd(input logic [7:0] i);
    int n;
    s_axi_araddr <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1'h1;
    for (n = 0; n < 60; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) break;
    end
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    if (n == 60)
    begin
      error_cnt++;
      report_and_stop();
    end
  endtask : rd
  task automatic chr(input logic [7:0] i, m, e);
    rd(i);
    chk(d & m, e);
  endtask : chr
  task automatic t_reset;
    chr(ucs_pkg::IDX_STATUS_A, 8'hFF, 8'h20);
    chr(ucs_pkg::IDX_CTRL_B, 8'hFF, 8'h00);
    chr(ucs_pkg::IDX_CTRL_C, 8'hFF, 8'h06);
    rd(8'hC9);
    chk({6'h0, r}, {6'h0, ucs_pkg::RESP_SLVERR});
    wr(8'hC9, 8'h00);
    chk({6'h0, r}, {6'h0, ucs_pkg::RESP_SLVERR});
  endtask : t_reset
  task automatic t_tx;
    wr(ucs_pkg::IDX_CTRL_B, 8'h18);
    // second byte waits in the buffer, third is written while full
    fork
      i_peer.take(d, ok);
      begin
        wr(ucs_pkg::IDX_DATA, 8'hA5);
        wr(ucs_pkg::IDX_DATA, 8'h5A);
        wr(ucs_pkg::IDX_DATA, 8'hFF);
        chr(ucs_pkg::IDX_STATUS_A, 8'h60, 8'h00);
      end
    join
    chk(d, 8'hA5);
    chk({7'h0, ok}, 8'h01);
    i_peer.take(d, ok);
    chk(d, 8'h5A);
    repeat (16) @(posedge aclk);
    chr(ucs_pkg::IDX_STATUS_A, 8'h60, 8'h60);
    wr(ucs_pkg::IDX_STATUS_A, 8'h00);
    chr(ucs_pkg::IDX_STATUS_A, 8'h40, 8'h40);
  endtask : t_tx
  task automatic t_irq;
    wr(ucs_pkg::IDX_IRQ_GLOBAL, 8'h01);
    wr(ucs_pkg::IDX_CTRL_B, 8'h78);
    repeat (2) @(posedge aclk);
    chk({6'h0, tx_complete_irq, tx_empty_irq}, 8'h03);
    tx_complete_irq_ack <= 1'h1;
    @(posedge aclk);
    tx_complete_irq_ack <= 1'h0;
    chr(ucs_pkg::IDX_STATUS_A, 8'h40, 8'h00);
    wr(ucs_pkg::IDX_IRQ_GLOBAL, 8'h00);
    repeat (2) @(posedge aclk);
    chk({7'h0, tx_empty_irq}, 8'h00);
  endtask : t_irq
  // second character carries a zero stop bit
  task automatic t_rx;
    wr(ucs_pkg::IDX_CTRL_B, 8'h98);
    chk({7'h0, rx_pin_owned}, 8'h01);
    wr(ucs_pkg::IDX_IRQ_GLOBAL, 8'h01);
    i_peer.send(8'h3C, 1'h1);
    i_peer.send(8'h5A, 1'h0);
    chk({7'h0, rx_complete_irq}, 8'h01);
    chr(ucs_pkg::IDX_STATUS_A, 8'h90, 8'h80);
    chr(ucs_pkg::IDX_DATA, 8'hFF, 8'h3C);
    chr(ucs_pkg::IDX_STATUS_A, 8'h90, 8'h90);
    chr(ucs_pkg::IDX_DATA, 8'hFF, 8'h5A);
    chr(ucs_pkg::IDX_STATUS_A, 8'h80, 8'h00);
    i_peer.send(8'h11, 1'h0);
    wr(ucs_pkg::IDX_CTRL_B, 8'h08);
    chr(ucs_pkg::IDX_STATUS_A, 8'h9C, 8'h00);
    chk({7'h0, rx_pin_owned}, 8'h00);
  endtask : t_rx
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    t_tx();
    t_irq();
    t_rx();
    report_and_stop();
  end
endmodule : uart_control_status_tb_top
